// ==== dv/sprw_agent_asserts.sv ====
// checker for the supervisory parameter read/write agent
`timescale 1ns/100ps
`include "sprw_defs.vh"
module sprw_asserts (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // message ports
  input wire rx_msg_valid,
  input wire rx_crc_ok,
  input wire [127:0] rx_msg,
  input wire tx_msg_valid,
  input wire [127:0] tx_msg,
  input wire tx_msg_ready,
  // register port and mode output
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire [`SPRW_MODE_W-1:0] mode_out_q
);
  logic pend_q, crc_q, men_q;
  logic [7:0] cmd_q;
  logic [15:0] tgt_q, pid_q;
  wire [7:0] rx_cmd = rx_msg[119:112];
  wire [7:0] tx_cmd = tx_msg[119:112];
  wire idle = rx_msg_valid && !tx_msg_valid && !pend_q && rx_msg[127:120] == `SPRW_TYPE_PRW;
  wire take = idle && rx_cmd inside {`SPRW_CMD_RD, `SPRW_CMD_WR, `SPRW_CMD_INC, `SPRW_CMD_DEC};
  wire ans = tx_msg_valid && pend_q;
  // remembers the request under service so its answer can be matched
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      crc_q <= 1'b0;
      men_q <= 1'b0;
      cmd_q <= 8'h00;
      tgt_q <= 16'h0000;
      pid_q <= 16'h0000;
    end else begin
      if (take) begin
        pend_q <= 1'b1;
        crc_q <= rx_crc_ok;
        cmd_q <= rx_cmd;
        tgt_q <= rx_msg[111:96];
        pid_q <= rx_msg[95:80];
      end else if (tx_msg_valid && tx_msg_ready) begin
        pend_q <= 1'b0;
      end
      if (reg_wr && reg_addr == `SPRW_REG_CTRL) begin
        men_q <= reg_wdata[1];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ans_time_a: assert property (take |=> !tx_msg_valid ##1 tx_msg_valid)
    else $error("answer not raised two edges after the request");
  tx_form_a: assert property (tx_msg_valid |-> tx_msg[127:120] == `SPRW_TYPE_PRW && tx_msg[15:0] == 16'h0000)
    else $error("outgoing type or check field wrong");
  tx_hold_a: assert property (tx_msg_valid && !tx_msg_ready |=> tx_msg_valid && $stable(tx_msg))
    else $error("outgoing message changed before it was taken");
  tgt_echo_a: assert property (ans |-> tx_msg[111:96] == tgt_q)
    else $error("answer target selector differs from request");
  pid_echo_a: assert property (ans |-> tx_msg[95:80] == pid_q)
    else $error("answer identifier differs from request");
  rd_answer_a: assert property (ans && cmd_q == `SPRW_CMD_RD |-> tx_cmd inside {8'h02, 8'h07, 8'h08})
    else $error("read answered with wrong command");
  wr_answer_a: assert property (ans && cmd_q == `SPRW_CMD_WR |-> tx_cmd inside {8'h06, 8'h07, 8'h08})
    else $error("write answered with wrong command");
  step_answer_a: assert property (ans && cmd_q inside {8'h04, 8'h05} |-> tx_cmd inside {8'h06, 8'h07, 8'h08})
    else $error("step answered with wrong command");
  crc_reject_a: assert property (ans && !crc_q |-> tx_cmd == `SPRW_CMD_ERR)
    else $error("bad check sequence not rejected");
  ro_reject_a: assert property (ans && cmd_q == `SPRW_CMD_WR && pid_q inside {16'hfff1, 16'hfff2, 16'hfff3, 16'hffff}
    |-> tx_cmd == `SPRW_CMD_ERR)
    else $error("write to read-only parameter not rejected");
  nopar_a: assert property (ans && crc_q && tgt_q <= 16'h0001 && (pid_q inside {[16'h0207:16'h0fff]}
    || (pid_q[15:9] == 7'h00 && pid_q[7:0] >= 8'h04)) |-> tx_cmd == `SPRW_CMD_NOPAR)
    else $error("missing parameter not answered with unsupported reject");
  nop_drop_a: assert property (idle && (rx_cmd == 8'h00 || rx_cmd >= 8'h09) |=> !tx_msg_valid [*4])
    else $error("dropped command produced an answer");
  mode_zero_a: assert property (!men_q && !$past(men_q) |-> mode_out_q == 17'h00000)
    else $error("mode codes not zero while reporting disabled");
  read_c: cover property (take && rx_cmd == `SPRW_CMD_RD);
  step_c: cover property (take && rx_cmd == `SPRW_CMD_INC);
  nopar_c: cover property (ans && tx_cmd == `SPRW_CMD_NOPAR);
endmodule
bind sprw_agent sprw_asserts i_sprw_asserts (.sys_clk(sys_clk), .arst_n(arst_n), .rx_msg_valid(rx_msg_valid),
  .rx_crc_ok(rx_crc_ok), .rx_msg(rx_msg), .tx_msg_valid(tx_msg_valid), .tx_msg(tx_msg),
  .tx_msg_ready(tx_msg_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .mode_out_q(mode_out_q));

// ==== dv/sprw_agent_tb.sv ====
// self-checking bench for the supervisory parameter read/write agent
`timescale 1ns/100ps
`include "sprw_defs.vh"
module sprw_agent_tb;
  localparam logic [63:0] PVER_V = 64'h5a5a_0000_0000_0000;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_msg_valid, rx_crc_ok, tx_msg_ready, tx_msg_valid, got;
  logic [127:0] rx_msg, tx_msg, rsp, msg;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, rd;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] rx_eq_q, tx_eq_q;
  logic [7:0] train_q, mflen_q;
  logic [7:0] link_state = 8'h3c;
  logic [16:0] mode_out_q;
  logic [7:0] rc[6] = '{8'h01, 8'h01, 8'h03, 8'h04, 8'h01, 8'h03};
  logic [15:0] rt[6] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
  logic [15:0] rp[6] = '{16'h0200, 16'h0200, 16'hfff1, 16'h0200, 16'h0004, 16'h0207};
  logic [7:0] re[6] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h08, 8'h08};
  logic [7:0] dc[4] = '{8'h00, 8'h09, 8'hff, 8'h01};
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  // identity code value is arbitrary
  sprw_agent #(.PVER_VAL(PVER_V), .IDCODE_VAL(32'h0000_0123)) i_sprw_agent (.sys_clk(sys_clk), .arst_n(arst_n),
    .rx_msg_valid(rx_msg_valid), .rx_crc_ok(rx_crc_ok), .rx_msg(rx_msg), .tx_msg_valid(tx_msg_valid),
    .tx_msg(tx_msg), .tx_msg_ready(tx_msg_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_eq_q(rx_eq_q), .tx_eq_q(tx_eq_q), .train_q(train_q),
    .mflen_q(mflen_q), .mode_out_q(mode_out_q), .link_state(link_state));
  sprw_peer i_sprw_peer (.sys_clk(sys_clk), .tx_msg_valid(tx_msg_valid), .tx_msg(tx_msg),
    .tx_msg_ready(tx_msg_ready), .rx_msg_valid(rx_msg_valid), .rx_crc_ok(rx_crc_ok), .rx_msg(rx_msg));
  function automatic logic [127:0] m(input logic [7:0] c, input logic [15:0] t, p, input logic [63:0] v);
    return {`SPRW_TYPE_PRW, c, t, p, v, 16'h0000};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ck(input string name, input logic [127:0] exp, input logic [127:0] act);
    tests_run++;
    if (act !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, act);
    end
  endtask
  task automatic rq(input logic [7:0] c, input logic [15:0] t, p, input logic [63:0] v, input int stall);
    i_sprw_peer.xfer(m(c, t, p, v), 1'b1, stall, rsp, got);
  endtask
  // a gap after each strobe keeps one assignment per signal per edge
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    ck("reset_outs", 128'h0, 128'({rx_eq_q, tx_eq_q, train_q, mflen_q, mode_out_q}));
    rq(8'h03, 16'h0000, 16'h0200, 64'ha5c3_0f0f_1234_5678, 3);
    ck("train_ack", m(8'h06, 16'h0000, 16'h0200, {8'ha5, ~56'hc3_0f0f_1234_5678}), rsp);
    ck("train_q", 128'(8'ha5), 128'(train_q));
    rq(8'h01, 16'h0001, 16'h0200, 64'h0, 0);
    ck("train_rd", m(8'h02, 16'h0001, 16'h0200, {8'ha5, 56'h0}), rsp);
    $display("test write_read done");
    rq(8'h03, 16'h0000, 16'h0002, {6'h10, 58'h0}, 1);
    ck("eq_wr", m(8'h06, 16'h0000, 16'h0002, {6'h10, {58{1'b1}}}), rsp);
    rq(8'h04, 16'h0000, 16'h0002, 64'h0, 0);
    ck("eq_inc", m(8'h06, 16'h0000, 16'h0002, {6'h11, 58'h0}), rsp);
    ck("rx_eq_q", 128'(6'h11), 128'(rx_eq_q[17:12]));
    rq(8'h05, 16'h0000, 16'h0002, 64'h0, 2);
    ck("eq_dec", m(8'h06, 16'h0000, 16'h0002, {6'h10, 58'h0}), rsp);
    rq(8'h03, 16'h0000, 16'h0101, {6'h2a, 58'h0}, 0);
    ck("tx_eq_q", 128'(6'h2a), 128'(tx_eq_q[11:6]));
    $display("test steps done");
    for (int i = 0; i < 6; i++) begin
      i_sprw_peer.xfer(m(rc[i], rt[i], rp[i], 64'h0), i != 0, 0, rsp, got);
      ck("reject", 128'({`SPRW_TYPE_PRW, re[i], rt[i], rp[i]}), 128'(rsp[127:80]));
    end
    for (int i = 0; i < 4; i++) begin
      msg = m(dc[i], 16'h0000, 16'h0200, 64'h0);
      if (i == 3)
        msg[127:120] = 8'h01;
      i_sprw_peer.xfer(msg, 1'b1, 0, rsp, got);
      ck("dropped", 128'(1'b0), 128'(got));
    end
    ck("train_kept", 128'(8'ha5), 128'(train_q));
    $display("test rejects done");
    rq(8'h01, 16'h0000, 16'hfff3, 64'h0, 0);
    ck("pver", m(8'h02, 16'h0000, 16'hfff3, PVER_V), rsp);
    rq(8'h01, 16'h0000, 16'h0204, 64'h0, 0);
    ck("state", m(8'h02, 16'h0000, 16'h0204, {8'h3c, 56'h0}), rsp);
    reg_write(`SPRW_REG_CTRL, 32'h1);
    reg_write(`SPRW_REG_LBL, 32'h1abcd);
    reg_write(`SPRW_REG_SEND, 32'h1);
    i_sprw_peer.take(2, rsp, got);
    ck("label_out", m(8'h03, 16'h0000, 16'h0202, {17'h1abcd, 47'h0}), rsp);
    rq(8'h03, 16'h0000, 16'h0202, {17'h0f0f1, 47'h0}, 0);
    ck("label_ack", 128'(8'h06), 128'(rsp[119:112]));
    reg_read(`SPRW_REG_RXLBL, rd);
    ck("rx_label", 128'(17'h0f0f1), 128'(rd));
    rq(8'h03, 16'h0000, 16'h0205, {17'h12345, 47'h0}, 0);
    rq(8'h01, 16'h0000, 16'h0205, 64'h0, 0);
    ck("exp_label", m(8'h02, 16'h0000, 16'h0205, {17'h12345, 47'h0}), rsp);
    reg_write(`SPRW_REG_CTRL, 32'h0);
    reg_read(`SPRW_REG_RXLBL, rd);
    ck("label_off", 128'h0, 128'(rd));
    $display("test label done");
    reg_write(`SPRW_REG_MODE, 32'h1f00f);
    ck("mode_off", 128'h0, 128'(mode_out_q));
    reg_write(`SPRW_REG_CTRL, 32'h2);
    @(posedge sys_clk);
    ck("mode_on", 128'(17'h1f00f), 128'(mode_out_q));
    reg_read(`SPRW_REG_CTRL, rd);
    ck("ctrl_rd", 128'(32'h2), 128'(rd));
    rq(8'h03, 16'h0000, 16'h0203, {17'h0a5a5, 47'h0}, 0);
    rq(8'h01, 16'h0000, 16'h0203, 64'h0, 1);
    ck("ann_mode", m(8'h02, 16'h0000, 16'h0203, {17'h0a5a5, 47'h0}), rsp);
    rq(8'h03, 16'h0001, 16'h0206, {17'h1c3c3, 47'h0}, 0);
    rq(8'h01, 16'h0000, 16'h0206, 64'h0, 0);
    ck("exp_mode", m(8'h02, 16'h0000, 16'h0206, {17'h1c3c3, 47'h0}), rsp);
    rq(8'h03, 16'h0000, 16'h0201, {8'h5c, 56'h0}, 0);
    ck("mflen_q", 128'(8'h5c), 128'(mflen_q));
    rq(8'h01, 16'h0000, 16'hffff, 64'h0, 0);
    ck("idcode", m(8'h02, 16'h0000, 16'hffff, {32'h0000_0123, 32'h0}), rsp);
    reg_read(4'hf, rd);
    ck("unmapped", 128'h0, 128'(rd));
    $display("test mode done");
    test_done();
  end
endmodule

// ==== dv/sprw_peer.sv ====
// far-side framing engine model: offers decoded requests, takes answers
`timescale 1ns/100ps
module sprw_peer (
  // clock
  input wire sys_clk,
  // answers from the agent
  input wire tx_msg_valid,
  input wire [127:0] tx_msg,
  output logic tx_msg_ready,
  // requests to the agent
  output logic rx_msg_valid,
  output logic rx_crc_ok,
  output logic [127:0] rx_msg
);
  initial begin
    tx_msg_ready = 1'b0;
    rx_msg_valid = 1'b0;
    rx_crc_ok = 1'b0;
    rx_msg = 128'h0;
  end
  // ready only after more than stall valid cycles, so slow acceptance is exercised
  task automatic take(input int stall, output logic [127:0] rsp, output logic got);
    int w;
    w = 0;
    got = 1'b0;
    rsp = 128'h0;
    for (int n = 0; n < 30 && !got; n++) begin
      @(negedge sys_clk);
      if (tx_msg_valid === 1'b1 && tx_msg_ready === 1'b1) begin
        rsp = tx_msg;
        got = 1'b1;
      end else if (tx_msg_valid === 1'b1) begin
        w++;
      end
      @(posedge sys_clk);
      tx_msg_ready <= !got && w > stall;
    end
  endtask
  // one-cycle offer; caller keeps to one request per answer
  task automatic xfer(input logic [127:0] msg, input logic ok, input int stall,
                      output logic [127:0] rsp, output logic got);
    rx_msg <= msg;
    rx_crc_ok <= ok;
    rx_msg_valid <= 1'b1;
    @(posedge sys_clk);
    rx_msg_valid <= 1'b0;
    rx_msg <= ~msg;
    rx_crc_ok <= ~ok;
    take(stall, rsp, got);
  endtask
endmodule

// ==== rtl/sprw_agent.v ====
// parameter read/write command interpreter for the supervisory channel
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "sprw_defs.vh"
module sprw_agent #(
  parameter [63:0] CLAUSE_VAL = 64'h0900000000000000,
  parameter [63:0] EVER_VAL = 64'h0100000000000000,
  parameter [63:0] PVER_VAL = 64'h0200000000000000,
  parameter [31:0] IDCODE_VAL = 32'h00000001
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // decoded incoming message from the framing engine
  input wire rx_msg_valid,
  input wire rx_crc_ok,
  input wire [127:0] rx_msg,
  // outgoing message to the framing engine
  output reg tx_msg_valid,
  output reg [127:0] tx_msg,
  input wire tx_msg_ready,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // parameter outputs to the rest of the link
  output reg [`SPRW_EQ_N*`SPRW_EQ_W-1:0] rx_eq_q,
  output reg [`SPRW_EQ_N*`SPRW_EQ_W-1:0] tx_eq_q,
  output reg [`SPRW_TRAIN_W-1:0] train_q,
  output reg [`SPRW_MF_W-1:0] mflen_q,
  output reg [`SPRW_MODE_W-1:0] mode_out_q,
  // link state input from the framing engine, same clock
  input wire [7:0] link_state
);

  // message fields in wire order, type in the top byte
  wire [7:0] f_type = rx_msg[127:120];
  wire [7:0] f_cmd = rx_msg[119:112];
  wire [15:0] f_target_link_selector = rx_msg[111:96];
  wire [15:0] f_pid = rx_msg[95:80];
  wire [63:0] f_val = rx_msg[79:16];

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_EXEC = 2'd1;
  localparam [1:0] ST_SEND = 2'd2;

  reg [1:0] st_q;
  reg [7:0] cmd_q;
  reg [15:0] target_link_selector_q;
  reg [15:0] pid_q;
  reg [63:0] val_q;
  reg crc_q;
  reg lbl_en_q;
  reg mode_en_q;
  reg [`SPRW_LBL_W-1:0] lbl_q;
  reg [`SPRW_LBL_W-1:0] rx_lbl_q;
  reg [`SPRW_LBL_W-1:0] exp_lbl_q;
  reg [`SPRW_MODE_W-1:0] mode_sw_q;
  reg [`SPRW_MODE_W-1:0] rx_mode_q;
  reg [`SPRW_MODE_W-1:0] exp_mode_q;
  reg send_req_q;
  reg [7:0] err_cnt_q;

  // identifier classes
  function [2:0] pid_class;
    input [15:0] parameter_identifier_field;
    begin
      if (parameter_identifier_field[15:8] == `SPRW_PID_RXEQ_HI) begin
        pid_class = 3'd1;
      end else if (parameter_identifier_field[15:8] == `SPRW_PID_TXEQ_HI) begin
        pid_class = 3'd2;
      end else if (parameter_identifier_field == `SPRW_PID_CLAUSE || parameter_identifier_field == `SPRW_PID_EVER || parameter_identifier_field == `SPRW_PID_PVER ||
                   parameter_identifier_field == `SPRW_PID_IDCODE) begin
        pid_class = 3'd3;
      end else if (parameter_identifier_field >= `SPRW_PID_TRAIN && parameter_identifier_field <= `SPRW_PID_EXP_MODE) begin
        pid_class = 3'd4;
      end else begin
        pid_class = 3'd0;
      end
    end
  endfunction

  // only equalizer numbers below the implemented count exist
  function pid_exists;
    input [15:0] parameter_identifier_field;
    begin
      case (pid_class(parameter_identifier_field))
        3'd1, 3'd2: pid_exists = (parameter_identifier_field[7:0] < `SPRW_EQ_N);
        3'd3, 3'd4: pid_exists = 1'b1;
        default: pid_exists = 1'b0;
      endcase
    end
  endfunction

  // labels and mode gated by their enables
  wire [`SPRW_LBL_W-1:0] lbl_eff = lbl_en_q ? lbl_q : {`SPRW_LBL_W{1'b0}};
  wire [`SPRW_MODE_W-1:0] mode_eff = mode_en_q ? mode_sw_q : {`SPRW_MODE_W{1'b0}};

  wire [1:0] eq_idx = pid_q[1:0];
  wire [`SPRW_EQ_W-1:0] rx_eq_sel = rx_eq_q[eq_idx*`SPRW_EQ_W +: `SPRW_EQ_W];
  wire [`SPRW_EQ_W-1:0] tx_eq_sel = tx_eq_q[eq_idx*`SPRW_EQ_W +: `SPRW_EQ_W];

  // current value, left justified in 64 bits
  reg [63:0] cur_val;
  always @* begin
    cur_val = 64'h0;
    case (pid_class(pid_q))
      3'd1: cur_val[63:64-`SPRW_EQ_W] = rx_eq_sel;
      3'd2: cur_val[63:64-`SPRW_EQ_W] = tx_eq_sel;
      3'd3: begin
        case (pid_q)
          `SPRW_PID_CLAUSE: cur_val = CLAUSE_VAL;
          `SPRW_PID_EVER: cur_val = EVER_VAL;
          `SPRW_PID_PVER: cur_val = PVER_VAL;
          default: cur_val[63:32] = IDCODE_VAL;
        endcase
      end
      3'd4: begin
        case (pid_q)
          `SPRW_PID_TRAIN: cur_val[63:64-`SPRW_TRAIN_W] = train_q;
          `SPRW_PID_MFLEN: cur_val[63:64-`SPRW_MF_W] = mflen_q;
          `SPRW_PID_ANN_LBL: cur_val[63:64-`SPRW_LBL_W] = rx_lbl_q;
          `SPRW_PID_ANN_MODE: cur_val[63:64-`SPRW_MODE_W] = rx_mode_q;
          `SPRW_PID_STATE: cur_val[63:56] = link_state;
          `SPRW_PID_EXP_LBL: cur_val[63:64-`SPRW_LBL_W] = exp_lbl_q;
          default: cur_val[63:64-`SPRW_MODE_W] = exp_mode_q;
        endcase
      end
      default: cur_val = 64'h0;
    endcase
  end

  // captured width of a writable parameter
  reg [6:0] cap_w;
  always @* begin
    cap_w = 7'd0;
    case (pid_class(pid_q))
      3'd1, 3'd2: cap_w = 7'd`SPRW_EQ_W;
      3'd4: begin
        case (pid_q)
          `SPRW_PID_TRAIN: cap_w = 7'd`SPRW_TRAIN_W;
          `SPRW_PID_MFLEN: cap_w = 7'd`SPRW_MF_W;
          `SPRW_PID_ANN_LBL, `SPRW_PID_EXP_LBL: cap_w = 7'd`SPRW_LBL_W;
          `SPRW_PID_ANN_MODE, `SPRW_PID_EXP_MODE: cap_w = 7'd`SPRW_MODE_W;
          default: cap_w = 7'd0;
        endcase
      end
      default: cap_w = 7'd0;
    endcase
  end

  // mask of captured bits, left justified
  wire [63:0] cap_mask = ~({64{1'b1}} >> cap_w);
  // write echo: captured bits echoed, the rest inverted
  wire [63:0] wr_echo = (val_q & cap_mask) | (~val_q & ~cap_mask);

  // step of inc/dec on equalizer taps; a step past either end is rejected
  wire is_inc = (cmd_q == `SPRW_CMD_INC);
  wire [`SPRW_EQ_W-1:0] eq_cur = (pid_class(pid_q) == 3'd1) ? rx_eq_sel : tx_eq_sel;
  wire [`SPRW_EQ_W:0] eq_up = {1'b0, eq_cur} + {1'b0, `SPRW_STEP};
  wire eq_step_bad = is_inc ? eq_up[`SPRW_EQ_W] : (eq_cur < `SPRW_STEP);
  wire [`SPRW_EQ_W-1:0] eq_stepped = is_inc ? eq_up[`SPRW_EQ_W-1:0] : (eq_cur - `SPRW_STEP);
  wire [`SPRW_EQ_W-1:0] eq_new = (cmd_q == `SPRW_CMD_WR) ? val_q[63:64-`SPRW_EQ_W] : eq_stepped;

  // decision for the held request
  wire is_wr_kind = (cmd_q == `SPRW_CMD_WR) || (cmd_q == `SPRW_CMD_INC) || (cmd_q == `SPRW_CMD_DEC);
  wire target_link_selector_ok = (target_link_selector_q == `SPRW_TARGET_LINK_SELECTOR_THIS) || (target_link_selector_q == `SPRW_TARGET_LINK_SELECTOR_RESP);
  wire step_only_eq = (cmd_q != `SPRW_CMD_WR) && (pid_class(pid_q) != 3'd1) && (pid_class(pid_q) != 3'd2);
  wire ro_hit = is_wr_kind && ((pid_class(pid_q) == 3'd3) || (pid_q == `SPRW_PID_STATE));
  wire ann_bad = is_wr_kind && (pid_q == `SPRW_PID_ANN_LBL || pid_q == `SPRW_PID_ANN_MODE) &&
                 (cmd_q != `SPRW_CMD_WR || target_link_selector_q != `SPRW_TARGET_LINK_SELECTOR_THIS);
  wire err_hit = !crc_q || !target_link_selector_ok || ro_hit || ann_bad || (is_wr_kind && step_only_eq) ||
                 (is_wr_kind && !step_only_eq && cmd_q != `SPRW_CMD_WR && eq_step_bad);
  wire nopar_hit = !pid_exists(pid_q);
  wire do_write = is_wr_kind && !err_hit && !nopar_hit;

  reg [7:0] resp_cmd;
  reg [63:0] resp_val;
  always @* begin
    resp_cmd = `SPRW_CMD_ERR;
    resp_val = val_q;
    if (nopar_hit && crc_q && target_link_selector_ok) begin
      resp_cmd = `SPRW_CMD_NOPAR;
    end else if (err_hit) begin
      resp_cmd = `SPRW_CMD_ERR;
    end else if (cmd_q == `SPRW_CMD_RD) begin
      resp_cmd = `SPRW_CMD_RD_ACK;
      resp_val = cur_val;
    end else if (cmd_q == `SPRW_CMD_WR) begin
      resp_cmd = `SPRW_CMD_WR_ACK;
      resp_val = wr_echo;
    end else begin
      resp_cmd = `SPRW_CMD_WR_ACK;
      resp_val = 64'h0;
      resp_val[63:64-`SPRW_EQ_W] = eq_stepped;
    end
  end

  wire rx_accept = rx_msg_valid && (st_q == ST_IDLE);
  wire rx_is_prw = (f_type == `SPRW_TYPE_PRW);
  wire rx_is_req = (f_cmd == `SPRW_CMD_RD) || (f_cmd == `SPRW_CMD_WR) || (f_cmd == `SPRW_CMD_INC) ||
                   (f_cmd == `SPRW_CMD_DEC);
  // command interpreter
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      cmd_q <= 8'h00;
      target_link_selector_q <= 16'h0000;
      pid_q <= 16'h0000;
      val_q <= 64'h0;
      crc_q <= 1'b0;
      tx_msg_valid <= 1'b0;
      tx_msg <= 128'h0;
      err_cnt_q <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (send_req_q) begin
            // own label announcement, local link only
            tx_msg <= {`SPRW_TYPE_PRW, `SPRW_CMD_WR, `SPRW_TARGET_LINK_SELECTOR_THIS, `SPRW_PID_ANN_LBL,
                       lbl_eff, {64-`SPRW_LBL_W{1'b0}}, 16'h0000};
            tx_msg_valid <= 1'b1;
            st_q <= ST_SEND;
          end else if (rx_accept && rx_is_prw && rx_is_req) begin
            cmd_q <= f_cmd;
            target_link_selector_q <= f_target_link_selector;
            pid_q <= f_pid;
            val_q <= f_val;
            crc_q <= rx_crc_ok;
            st_q <= ST_EXEC;
          end
          // nop and reserved commands fall through with no answer
        end
        ST_EXEC: begin
          // answers echo target and identifier; crc filled by the framer
          tx_msg <= {`SPRW_TYPE_PRW, resp_cmd, target_link_selector_q, pid_q, resp_val, 16'h0000};
          tx_msg_valid <= 1'b1;
          if (resp_cmd == `SPRW_CMD_ERR || resp_cmd == `SPRW_CMD_NOPAR) begin
            err_cnt_q <= err_cnt_q + 8'h01;
          end
          st_q <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_msg_ready) begin
            tx_msg_valid <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // announcement from peer, carried on the local link
  wire rx_ann = rx_accept && rx_is_prw && rx_crc_ok && (f_cmd == `SPRW_CMD_WR) &&
                (f_target_link_selector == `SPRW_TARGET_LINK_SELECTOR_THIS) && !send_req_q;

  // parameter store and software registers
  wire exec_wr = (st_q == ST_EXEC) && do_write;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_eq_q <= {`SPRW_EQ_N*`SPRW_EQ_W{1'b0}};
      tx_eq_q <= {`SPRW_EQ_N*`SPRW_EQ_W{1'b0}};
      train_q <= {`SPRW_TRAIN_W{1'b0}};
      mflen_q <= {`SPRW_MF_W{1'b0}};
      lbl_en_q <= 1'b0;
      mode_en_q <= 1'b0;
      lbl_q <= {`SPRW_LBL_W{1'b0}};
      rx_lbl_q <= {`SPRW_LBL_W{1'b0}};
      exp_lbl_q <= {`SPRW_LBL_W{1'b0}};
      mode_sw_q <= {`SPRW_MODE_W{1'b0}};
      rx_mode_q <= {`SPRW_MODE_W{1'b0}};
      exp_mode_q <= {`SPRW_MODE_W{1'b0}};
      mode_out_q <= {`SPRW_MODE_W{1'b0}};
      send_req_q <= 1'b0;
    end else begin
      mode_out_q <= mode_eff;
      if (exec_wr) begin
        case (pid_class(pid_q))
          3'd1: rx_eq_q[eq_idx*`SPRW_EQ_W +: `SPRW_EQ_W] <= eq_new;
          3'd2: tx_eq_q[eq_idx*`SPRW_EQ_W +: `SPRW_EQ_W] <= eq_new;
          default: begin
            case (pid_q)
              `SPRW_PID_TRAIN: train_q <= val_q[63:64-`SPRW_TRAIN_W];
              `SPRW_PID_MFLEN: mflen_q <= val_q[63:64-`SPRW_MF_W];
              `SPRW_PID_EXP_LBL: exp_lbl_q <= val_q[63:64-`SPRW_LBL_W];
              `SPRW_PID_EXP_MODE: exp_mode_q <= val_q[63:64-`SPRW_MODE_W];
              `SPRW_PID_ANN_LBL: rx_lbl_q <= lbl_en_q ? val_q[63:64-`SPRW_LBL_W] : {`SPRW_LBL_W{1'b0}};
              `SPRW_PID_ANN_MODE: rx_mode_q <= mode_en_q ? val_q[63:64-`SPRW_MODE_W] : {`SPRW_MODE_W{1'b0}};
              default: train_q <= train_q;
            endcase
          end
        endcase
      end
      // disabling labelling clears what was received
      if (!lbl_en_q) begin
        rx_lbl_q <= {`SPRW_LBL_W{1'b0}};
      end
      if (!mode_en_q) begin
        rx_mode_q <= {`SPRW_MODE_W{1'b0}};
      end
      if (reg_wr) begin
        case (reg_addr)
          `SPRW_REG_CTRL: begin
            lbl_en_q <= reg_wdata[0];
            mode_en_q <= reg_wdata[1];
          end
          `SPRW_REG_LBL: lbl_q <= reg_wdata[`SPRW_LBL_W-1:0];
          `SPRW_REG_MODE: mode_sw_q <= reg_wdata[`SPRW_MODE_W-1:0];
          `SPRW_REG_EXPLBL: exp_lbl_q <= reg_wdata[`SPRW_LBL_W-1:0];
          default: lbl_q <= lbl_q;
        endcase
      end
      // send request set by software, cleared once the message is queued
      if (reg_wr && reg_addr == `SPRW_REG_SEND && reg_wdata[0] && lbl_en_q) begin
        send_req_q <= 1'b1;
      end else if (st_q == ST_IDLE) begin
        send_req_q <= 1'b0;
      end
    end
  end

  // register read, data one cycle after the strobe
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPRW_REG_CTRL: reg_rdata <= {30'h0, mode_en_q, lbl_en_q};
        `SPRW_REG_LBL: reg_rdata <= {{32-`SPRW_LBL_W{1'b0}}, lbl_q};
        `SPRW_REG_MODE: reg_rdata <= {{32-`SPRW_MODE_W{1'b0}}, mode_sw_q};
        `SPRW_REG_RXLBL: reg_rdata <= {{32-`SPRW_LBL_W{1'b0}}, rx_lbl_q};
        `SPRW_REG_EXPLBL: reg_rdata <= {{32-`SPRW_LBL_W{1'b0}}, exp_lbl_q};
        `SPRW_REG_STAT: reg_rdata <= {20'h0, err_cnt_q, send_req_q, tx_msg_valid, st_q};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // rx_ann only notes that a peer write reached us; accepted as a normal request
  wire unused_ann = rx_ann;

endmodule

// ==== rtl/sprw_defs.vh ====
// constants for the supervisory parameter read/write agent
// Summary of operation
// - message: type 8, command 8, target 16, identifier 16, value 64, check 16
// - type field is 02 for parameter read/write messages
// - read request 01 answered by read response 02 with parameter value
// - write request 03 loads parameter, answered by write response 06
// - increment 04 and decrement 05 step by own step, answer with 06
// - erroneous request answered with error reject 07
// - unimplemented parameter answered with unsupported-parameter reject 08
// - target 0000 is carrying link, 0001 response link, others reserved/vendor
// - every answer copies the request's target selector
// - every answer copies the request's parameter identifier
// - identifiers 0000-00ff receiver, 0100-01ff transmitter equalizer
// - 0200 pattern, 0201 multiframe, 0202-0204 label/mode/state, 0205-0206 expected
// - ff f1, fff2, fff3, ffff are read only
// - announced label sent only in a write to target 0000
// - expected label and expected mode can be set or read by a peer
// - narrow parameters sit left justified in the 64-bit value
// - write response echoes captured bits, complements uncaptured ones
// - transmitter sends its software-set connection label when enabled
// - receiver stores received connection label, readable by software
// - label bits are zero when labelling disabled
// - mode word: application 16:9, aggregation 8:4, framing 3:0
// - the channel rides on supervisory overhead bit 0
// - flags, bit stuffing and crc-16 are done by the framing engine
// - mode reporting defaults off, mode codes held at zero
`ifndef SPRW_DEFS_VH
`define SPRW_DEFS_VH
`define SPRW_TYPE_PRW 8'h02
`define SPRW_CMD_NOP 8'h00
`define SPRW_CMD_RD 8'h01
`define SPRW_CMD_RD_ACK 8'h02
`define SPRW_CMD_WR 8'h03
`define SPRW_CMD_INC 8'h04
`define SPRW_CMD_DEC 8'h05
`define SPRW_CMD_WR_ACK 8'h06
`define SPRW_CMD_ERR 8'h07
`define SPRW_CMD_NOPAR 8'h08
`define SPRW_TARGET_LINK_SELECTOR_THIS 16'h0000
`define SPRW_TARGET_LINK_SELECTOR_RESP 16'h0001
`define SPRW_PID_RXEQ_HI 8'h00
`define SPRW_PID_TXEQ_HI 8'h01
`define SPRW_PID_TRAIN 16'h0200
`define SPRW_PID_MFLEN 16'h0201
`define SPRW_PID_ANN_LBL 16'h0202
`define SPRW_PID_ANN_MODE 16'h0203
`define SPRW_PID_STATE 16'h0204
`define SPRW_PID_EXP_LBL 16'h0205
`define SPRW_PID_EXP_MODE 16'h0206
`define SPRW_PID_CLAUSE 16'hfff1
`define SPRW_PID_EVER 16'hfff2
`define SPRW_PID_PVER 16'hfff3
`define SPRW_PID_IDCODE 16'hffff
`define SPRW_EQ_W 6
`define SPRW_EQ_N 4
`define SPRW_LBL_W 17
`define SPRW_MODE_W 17
`define SPRW_TRAIN_W 8
`define SPRW_MF_W 8
`define SPRW_STEP 6'h01
`define SPRW_REG_CTRL 4'h0
`define SPRW_REG_LBL 4'h1
`define SPRW_REG_MODE 4'h2
`define SPRW_REG_RXLBL 4'h3
`define SPRW_REG_EXPLBL 4'h4
`define SPRW_REG_STAT 4'h5
`define SPRW_REG_SEND 4'h6
`endif
